// [include/eps_pkg.sv]
// Purpose: Constants for the external program select block
// Assumes: 250 MHz mclk
// Notes: Times in their own unit, cycle counts derived from the clock rate
package eps_pkg;
    localparam int CLK_HZ = 250000000;
    localparam int PROG_COUNT = 64;
    localparam int PROG_W = 6;
    localparam int SEL_W = 4;
    localparam int EXT_PROG_MAX = 15;
    localparam int TAKE_HOLD_MS = 200;
    localparam longint TAKE_HOLD_CYC_L = (longint'(CLK_HZ) / 1000) * TAKE_HOLD_MS;
    localparam int TAKE_HOLD_CYC = int'(TAKE_HOLD_CYC_L);
    localparam int IDENT_W = 4;
    localparam logic [5:0] PROG_RESET = 6'h00;
    localparam logic [3:0] IDENT_RESET = 4'h0;
    localparam int STARTUP_SAMPLE_CYC = 4;
    // Program source encoding on the status output
    localparam logic [1:0] SRC_NONE = 2'h0;
    localparam logic [1:0] SRC_PINS = 2'h1;
    localparam logic [1:0] SRC_SW = 2'h2;
endpackage

// [verilog/eps_external_program_select.sv]
// Purpose: Pin-level program selection and station identity capture
// Assumes: Strobe and select pins asynchronous to mclk; software port writes program numbers directly
// Notes: Register port holds the active program, pins select only 0 to 15
//
// Summary of operation
// R1: The block holds one active program number out of sixty-four.
// R2: The select pins reach only programs 0 to 15; higher ones come from software only.
// R3: The four select pins form a binary number with weights 1, 2, 4 and 8.
// R4: The controller sets the select pins before raising the take strobe.
// R5: The controller holds the take strobe high for at least 200 ms.
// R6: A valid take strobe latches the select pins as the active program.
// R7: A pin program change is accepted at any time, in any operating phase.
// R8: A strobe already high at power-up adopts the pin program at startup.
// R9: The station identity 1 to 15 comes from four shared pins, high meaning set.
// R10: Each shared pin is sampled once at switch-on; high pins are inputs, low ones outputs.
// R11: Strobe and selects are resynchronised and the strobe must stay high 200 ms.
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module eps_external_program_select #(
    parameter int TAKE_HOLD_CYCLES = eps_pkg::TAKE_HOLD_CYC,
    parameter int STARTUP_CYCLES = eps_pkg::STARTUP_SAMPLE_CYC
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic program_select_bit_w1,
    input wire logic program_select_bit_w2,
    input wire logic program_select_bit_w4,
    input wire logic program_select_bit_w8,
    input wire logic program_take_strobe,
    input wire logic [3:0] sharedPinIn,
    input wire logic [3:0] sharedOutData,
    output logic [3:0] sharedPinOut,
    output logic [3:0] sharedPinOe,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    output logic [5:0] activeProgram,
    output logic [1:0] programSource,
    output logic programChanged,
    output logic [3:0] fieldbus_station_identity,
    output logic startupDone
);
    // Register map of the software port
    localparam logic [7:0] ADDR_PROG = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h01;
    localparam logic [7:0] ADDR_IDENT = 8'h02;

    typedef enum logic [1:0] {
        EPS_BOOT,
        EPS_IDLE,
        EPS_HOLD,
        EPS_WAIT_LOW
    } eps_state_t;

    localparam int CNT_W = $clog2(TAKE_HOLD_CYCLES + 1);
    localparam int BOOT_W = $clog2(STARTUP_CYCLES + 1);

    eps_state_t state_q;
    logic [1:0] strobeSync_q;
    logic [3:0] selSync1_q;
    logic [3:0] selSync2_q;
    logic [CNT_W-1:0] holdCnt_q;
    logic [BOOT_W-1:0] bootCnt_q;
    logic [3:0] inputMask_q;
    logic pinTake;
    logic swTake;
    logic [5:0] swProg;

    // Two-flop synchronisers for strobe and selects
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            strobeSync_q <= 2'h0;
            selSync1_q <= 4'h0;
            selSync2_q <= 4'h0;
        end else begin
            strobeSync_q <= {strobeSync_q[0], program_take_strobe}; // R11
            selSync1_q <= {program_select_bit_w8, program_select_bit_w4,
                           program_select_bit_w2, program_select_bit_w1}; // R3
            selSync2_q <= selSync1_q; // R11
        end
    end

    // Startup settling counter
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            bootCnt_q <= '0;
        end else if (state_q == EPS_BOOT) begin
            bootCnt_q <= bootCnt_q + BOOT_W'(1);
        end
    end

    // Strobe qualification state machine
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_q <= EPS_BOOT;
            holdCnt_q <= '0;
        end else begin
            unique case (state_q)
                EPS_BOOT: begin
                    if (bootCnt_q == BOOT_W'(STARTUP_CYCLES)) begin
                        // Strobe already high at startup takes pins now
                        state_q <= strobeSync_q[1] ? EPS_WAIT_LOW : EPS_IDLE; // R8
                    end
                end
                EPS_IDLE: begin
                    holdCnt_q <= '0;
                    if (strobeSync_q[1]) begin
                        state_q <= EPS_HOLD; // R7
                        holdCnt_q <= CNT_W'(1);
                    end
                end
                EPS_HOLD: begin
                    if (!strobeSync_q[1]) begin
                        state_q <= EPS_IDLE; // R11
                    end else if (holdCnt_q >= CNT_W'(TAKE_HOLD_CYCLES)) begin
                        state_q <= EPS_WAIT_LOW; // R11
                    end else begin
                        holdCnt_q <= holdCnt_q + CNT_W'(1);
                    end
                end
                EPS_WAIT_LOW: begin
                    // One take per strobe pulse
                    if (!strobeSync_q[1]) begin
                        state_q <= EPS_IDLE;
                    end
                end
            endcase
        end
    end

    // Take events
    assign pinTake = ((state_q == EPS_HOLD) && strobeSync_q[1]
                      && (holdCnt_q >= CNT_W'(TAKE_HOLD_CYCLES)))
                     || ((state_q == EPS_BOOT) && (bootCnt_q == BOOT_W'(STARTUP_CYCLES))
                         && strobeSync_q[1]); // R6 R8
    assign swTake = regWrite && (regAddr == ADDR_PROG);
    assign swProg = regWdata[5:0]; // R1 R2

    // Active program store, pins win over a same-cycle software write
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            activeProgram <= eps_pkg::PROG_RESET;
            programSource <= eps_pkg::SRC_NONE;
            programChanged <= 1'b0;
        end else begin
            programChanged <= pinTake || swTake;
            if (pinTake) begin
                activeProgram <= {2'h0, selSync2_q}; // R2 R6
                programSource <= eps_pkg::SRC_PINS;
            end else if (swTake) begin
                activeProgram <= swProg; // R1
                programSource <= eps_pkg::SRC_SW;
            end
        end
    end

    // Shared pin sampling once at switch-on
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            inputMask_q <= 4'h0;
            fieldbus_station_identity <= eps_pkg::IDENT_RESET;
            startupDone <= 1'b0;
        end else if (!startupDone && (bootCnt_q == BOOT_W'(STARTUP_CYCLES))) begin
            inputMask_q <= sharedPinIn; // R10
            fieldbus_station_identity <= sharedPinIn; // R9
            startupDone <= 1'b1;
        end
    end

    // Low pins become outputs after startup
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sharedPinOe <= 4'h0;
            sharedPinOut <= 4'h0;
        end else begin
            sharedPinOe <= startupDone ? ~inputMask_q : 4'h0; // R10
            sharedPinOut <= startupDone ? (sharedOutData & ~inputMask_q) : 4'h0;
        end
    end

    // Read data one cycle after the read strobe
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            unique case (regAddr)
                ADDR_PROG: regRdata <= {2'h0, activeProgram};
                ADDR_STATUS: regRdata <= {3'h0, startupDone, strobeSync_q[1],
                                          (state_q == EPS_HOLD), programSource};
                ADDR_IDENT: regRdata <= {inputMask_q, fieldbus_station_identity};
                default: regRdata <= 8'h00;
            endcase
        end else begin
            regRdata <= 8'h00;
        end
    end
endmodule

// [verification/eps_sel_assertions.sv]
// Purpose: Port checks for the program select block
// Assumes: Bound into the block, one clock
// Notes: Hold and startup counts come from the bind
`timescale 1ns/1ps
module eps_sel_assertions #(
    parameter int TAKE_HOLD_CYCLES = 20,
    parameter int STARTUP_CYCLES = 4
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic program_take_strobe,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdata,
    input wire logic [5:0] activeProgram,
    input wire logic [1:0] programSource,
    input wire logic programChanged,
    input wire logic [3:0] sharedPinOut,
    input wire logic [3:0] sharedPinOe,
    input wire logic [3:0] fieldbus_station_identity,
    input wire logic startupDone
);
    int bootCnt;
    int hiCnt;
    // Cycles since reset, length of strobe high run
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            bootCnt <= 0;
            hiCnt <= 0;
        end else begin
            bootCnt <= (bootCnt < 1000) ? bootCnt + 1 : bootCnt;
            hiCnt <= program_take_strobe ? hiCnt + 1 : 0;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence s_settled;
        startupDone ##1 startupDone;
    endsequence
    a_pin_range: assert property (programChanged && programSource == eps_pkg::SRC_PINS
        |-> activeProgram[5:4] == 2'h0) else $error("pin program above 15");
    a_take_hold: assert property (programChanged && programSource == eps_pkg::SRC_PINS
        && bootCnt > STARTUP_CYCLES + 4 |-> hiCnt >= TAKE_HOLD_CYCLES) else $error("short take");
    a_write_prog: assert property (regWrite && regAddr == 8'h00 |=> programChanged &&
        ({2'h0, activeProgram} == ($past(regWdata) & 8'h3f) || programSource == eps_pkg::SRC_PINS))
        else $error("write not applied");
    a_read_prog: assert property (regRead && regAddr == 8'h00
        |=> regRdata == {2'h0, $past(activeProgram)}) else $error("bad program read");
    a_read_idle: assert property (!regRead |=> regRdata == 8'h00) else $error("read data stuck");
    a_oe_split: assert property (s_settled |-> sharedPinOe == ~fieldbus_station_identity)
        else $error("enable not from sample");
    a_out_mask: assert property (s_settled |-> (sharedPinOut & ~sharedPinOe) == 4'h0)
        else $error("input pin driven");
    a_boot_time: assert property ($rose(startupDone) |-> bootCnt == STARTUP_CYCLES + 1)
        else $error("startup sample late");
endmodule
bind eps_external_program_select eps_sel_assertions #(.TAKE_HOLD_CYCLES(TAKE_HOLD_CYCLES),
    .STARTUP_CYCLES(STARTUP_CYCLES)) i_chk (.mclk, .rstn, .program_take_strobe, .regAddr,
    .regWdata, .regWrite, .regRead, .regRdata, .activeProgram, .programSource, .programChanged,
    .sharedPinOut, .sharedPinOe, .fieldbus_station_identity, .startupDone);

// [verification/eps_plc_model.sv]
// Purpose: External controller on select and strobe pins
// Assumes: Bench calls its tasks just after a clock edge
// Notes: Short holds only where the bench asks
`timescale 1ns/1ps
module eps_plc_model (
    input wire logic mclk,
    output logic [3:0] sel,
    output logic strobe
);
    initial begin
        sel = 4'h0;
        strobe = 1'b0;
    end
    // Static levels, as when the strobe is wired high
    task automatic park(input logic [3:0] num, input logic lvl);
        sel <= num;
        strobe <= lvl;
    endtask
    // Select first, then strobe held for hold cycles
    task automatic take(input logic [3:0] num, input int hold);
        sel <= num;
        repeat (3) @(posedge mclk);
        strobe <= 1'b1;
        repeat (hold) @(posedge mclk);
        strobe <= 1'b0;
    endtask
endmodule

// [verification/tb.sv]
// Purpose: Self-checking bench for program select
// Assumes: Short hold count of 20 cycles
// Notes: Random data from a fixed-seed shift register
`timescale 1ns/1ps
module tb;
    localparam int HOLD = 20;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] sharedPinIn = 4'h0;
    logic [3:0] sharedOutData = 4'h0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] regRdata;
    logic [5:0] activeProgram;
    logic [1:0] programSource;
    logic [3:0] sharedPinOe;
    logic [3:0] sharedPinOut;
    logic [3:0] fieldbus_station_identity;
    logic startupDone;
    logic [3:0] sel;
    logic strobe;
    logic [15:0] rnd = 16'h1adf;
    int error_cnt = 0;
    int num_checks = 0;
    eps_external_program_select #(.TAKE_HOLD_CYCLES(HOLD), .STARTUP_CYCLES(4)) i_dut (.mclk,
        .rstn, .program_select_bit_w1(sel[0]), .program_select_bit_w2(sel[1]),
        .program_select_bit_w4(sel[2]), .program_select_bit_w8(sel[3]),
        .program_take_strobe(strobe), .sharedPinIn, .sharedOutData, .sharedPinOut,
        .sharedPinOe, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .activeProgram,
        .programSource, .programChanged(), .fieldbus_station_identity, .startupDone);
    eps_plc_model i_plc (.mclk, .sel, .strobe);
    initial forever #2 mclk = ~mclk;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        #1;
        chk(regRdata, e);
    endtask
    // Power-up with strobe wired high and given shared pins
    task automatic boot(input logic [3:0] s, input logic [3:0] p);
        int n;
        @(posedge mclk);
        rstn <= 1'b0;
        i_plc.park(s, 1'b1);
        sharedPinIn <= p;
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        for (n = 0; n < 50 && startupDone !== 1'b1; n++) @(posedge mclk);
        if (n == 50) begin
            error_cnt++;
            summarize();
        end
        repeat (3) @(posedge mclk);
        chk({2'h0, activeProgram}, {4'h0, s});
        chk({4'h0, fieldbus_station_identity}, {4'h0, p});
        chk({4'h0, sharedPinOe}, {4'h0, ~p});
        i_plc.park(s, 1'b0);
        sharedPinIn <= ~p;
    endtask
    initial begin
        boot(4'hb, 4'h5);
        boot(4'h6, 4'ha);
        rnd = lfsr(rnd);
        sharedOutData <= rnd[11:8];
        wr(8'h00, rnd[7:0]);
        @(posedge mclk);
        chk({2'h0, activeProgram}, {2'h0, rnd[5:0]});
        wr(8'h05, 8'h3f);
        rd(8'h00, {2'h0, rnd[5:0]});
        rd(8'h7f, 8'h00);
        rd(8'h01, 8'h12);
        rd(8'h02, 8'haa);
        for (int k = 0; k < 16; k++) begin
            rnd = lfsr(rnd);
            sharedOutData <= rnd[3:0];
            i_plc.take(4'(k), HOLD + 8);
            repeat (2) @(posedge mclk);
            chk({2'h0, activeProgram}, 8'(k));
            chk({4'h0, sharedPinOut}, {4'h0, rnd[3:0] & 4'h5});
        end
        i_plc.take(4'h3, HOLD - 6);
        repeat (8) @(posedge mclk);
        chk({2'h0, activeProgram}, 8'h0f);
        rd(8'h01, 8'h11);
        summarize();
    end
endmodule
